// [rtc_calendar.sv]
// Real-time clock with calendar, two alarms, stopwatch and tick events over AXI4-Lite.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module rtc_calendar #(
  parameter int PRESCALE = `PRESCALE_DIV,
  parameter int SW_W = `SW_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic xtal_in,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic one_hz_calibration_out,
  output logic alarm1_irq,
  output logic alarm2_irq,
  output logic stopwatch_irq,
  output logic tick_irq
);
  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  localparam logic [PW-1:0] PRE_HALF = PW'(PRESCALE / 2);

  logic xtal_q;
  logic xtal_tick;
  logic [PW-1:0] presc_q;
  logic one_hz_tick;
  logic [31:0] ctrl_q;
  logic [31:0] al1_q;
  logic [31:0] al2_time_q;
  logic [31:0] al2_day_q;
  logic [SW_W-1:0] sw_q;
  rtc_pkg::sw_state_e sw_state_q;
  rtc_pkg::evt_t stat_q;
  rtc_pkg::evt_t evt_d;
  rtc_pkg::evt_t evt_q;
  logic [1:0] match_q;
  logic [5:0] sec;
  logic [5:0] min;
  logic [4:0] hour;
  logic [14:0] day;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic [31:0] time_now;
  logic [31:0] day_now;
  logic al1_match;
  logic al2_match;
  logic sw_under;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] wr_word;
  logic [31:0] wr_base;
  logic rd_ok;
  logic [31:0] rd_word;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Crystal edges, sampled on core_clk, are the only time base; counting stops whenever core_clk stops.
  assign xtal_tick = xtal_in && !xtal_q;
  assign one_hz_tick = ctrl_q[`CTRL_RUN] && xtal_tick && (presc_q == PRE_LAST); // RULE1

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xtal_q <= 1'b0;
    end else begin
      xtal_q <= xtal_in;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_q <= '0;
    end else if (ctrl_q[`CTRL_RUN] && xtal_tick) begin
      presc_q <= (presc_q == PRE_LAST) ? '0 : presc_q + 1'b1; // RULE1 RULE9
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      one_hz_calibration_out <= 1'b0;
    end else begin
      one_hz_calibration_out <= presc_q < PRE_HALF; // RULE8
    end
  end

  // Write merge and time-field loads.
  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign time_now = {11'h000, hour, 2'h0, min, 2'h0, sec};
  assign day_now = {17'h00000, day};

  always_comb begin
    wr_ok = 1'b1;
    if (waddr_q == `OFF_CTRL) begin
      wr_base = ctrl_q;
    end else if (waddr_q == `OFF_TIME) begin
      wr_base = time_now;
    end else if (waddr_q == `OFF_DAY) begin
      wr_base = day_now;
    end else if (waddr_q == `OFF_AL1_TIME) begin
      wr_base = al1_q;
    end else if (waddr_q == `OFF_AL2_TIME) begin
      wr_base = al2_time_q;
    end else if (waddr_q == `OFF_AL2_DAY) begin
      wr_base = al2_day_q;
    end else if (waddr_q == `OFF_SW) begin
      wr_base = 32'(sw_q);
    end else if (waddr_q == `OFF_STAT) begin
      wr_base = 32'h0000_0000;
    end else begin
      wr_base = 32'h0000_0000;
      wr_ok = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      wr_word[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : wr_base[i*8 +: 8];
    end
  end

  rtc_wrap_counter #(.W(6), .MOD(`SEC_MOD)) sec_cnt (
    .core_clk(core_clk), .rst(rst), .inc(one_hz_tick),
    .load(wr_fire && waddr_q == `OFF_TIME),
    .load_val(wr_word[`TIME_SEC_LSB +: 6]), .value(sec), .wrap(sec_wrap)
  ); // RULE2
  rtc_wrap_counter #(.W(6), .MOD(`MIN_MOD)) min_cnt (
    .core_clk(core_clk), .rst(rst), .inc(sec_wrap),
    .load(wr_fire && waddr_q == `OFF_TIME),
    .load_val(wr_word[`TIME_MIN_LSB +: 6]), .value(min), .wrap(min_wrap)
  ); // RULE10
  rtc_wrap_counter #(.W(5), .MOD(`HOUR_MOD)) hour_cnt (
    .core_clk(core_clk), .rst(rst), .inc(min_wrap),
    .load(wr_fire && waddr_q == `OFF_TIME),
    .load_val(wr_word[`TIME_HOUR_LSB +: 5]), .value(hour), .wrap(hour_wrap)
  ); // RULE10
  rtc_wrap_counter #(.W(15), .MOD(`DAY_MOD)) day_cnt (
    .core_clk(core_clk), .rst(rst), .inc(hour_wrap),
    .load(wr_fire && waddr_q == `OFF_DAY),
    .load_val(wr_word[14:0]), .value(day), .wrap()
  ); // RULE10

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RST;
      al1_q <= 32'h0000_0000;
      al2_time_q <= 32'h0000_0000;
      al2_day_q <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (waddr_q == `OFF_CTRL) begin
        ctrl_q <= wr_word & 32'h0000_00FF;
      end else if (waddr_q == `OFF_AL1_TIME) begin
        al1_q <= wr_word & `TIME_MASK;
      end else if (waddr_q == `OFF_AL2_TIME) begin
        al2_time_q <= wr_word & `TIME_MASK;
      end else if (waddr_q == `OFF_AL2_DAY) begin
        al2_day_q <= wr_word & `DAY_MASK;
      end
    end
  end

  // Stopwatch: a write loads and starts it; a tick at zero is the underflow.
  assign sw_under = (sw_state_q == rtc_pkg::SW_RUN) && one_hz_tick && (sw_q == '0) &&
                    !(wr_fire && waddr_q == `OFF_SW);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_q <= '0;
      sw_state_q <= rtc_pkg::SW_IDLE;
    end else if (wr_fire && waddr_q == `OFF_SW) begin
      sw_q <= wr_word[SW_W-1:0]; // RULE5
      sw_state_q <= rtc_pkg::SW_RUN;
    end else begin
      case (sw_state_q)
        rtc_pkg::SW_RUN: begin
          if (one_hz_tick) begin
            if (sw_q == '0) begin
              sw_state_q <= rtc_pkg::SW_IDLE; // RULE6
            end else begin
              sw_q <= sw_q - 1'b1; // RULE5
            end
          end
        end
        default: begin
          sw_state_q <= rtc_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // Alarms fire once, on the cycle after the match begins.
  assign al1_match = (time_now == al1_q); // RULE4
  assign al2_match = (time_now == al2_time_q) && (day_now == al2_day_q); // RULE4

  always_comb begin
    evt_d = '0;
    evt_d[`ST_AL1] = ctrl_q[`CTRL_AL1] && al1_match && !match_q[0]; // RULE3
    evt_d[`ST_AL2] = ctrl_q[`CTRL_AL2] && al2_match && !match_q[1]; // RULE3
    evt_d[`ST_SW] = ctrl_q[`CTRL_SW] && sw_under; // RULE6
    evt_d[`ST_TSEC] = ctrl_q[`CTRL_TSEC] && one_hz_tick; // RULE7
    evt_d[`ST_TMIN] = ctrl_q[`CTRL_TMIN] && sec_wrap; // RULE7
    evt_d[`ST_THOUR] = ctrl_q[`CTRL_THOUR] && min_wrap; // RULE7
    evt_d[`ST_TDAY] = ctrl_q[`CTRL_TDAY] && hour_wrap; // RULE7
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      match_q <= 2'h0;
      evt_q <= '0;
    end else begin
      match_q <= {al2_match, al1_match};
      evt_q <= evt_d;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else if (wr_fire && waddr_q == `OFF_STAT) begin
      stat_q <= (stat_q & ~wr_word[6:0]) | evt_d;
    end else begin
      stat_q <= stat_q | evt_d;
    end
  end

  assign alarm1_irq = evt_q[`ST_AL1];
  assign alarm2_irq = evt_q[`ST_AL2];
  assign stopwatch_irq = evt_q[`ST_SW];
  assign tick_irq = |evt_q[`ST_TDAY:`ST_TSEC];

  // AXI4-Lite write channel: address and data taken in either order.
  assign awready = !aw_have_q;
  assign wready = !w_have_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        waddr_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel.
  always_comb begin
    rd_ok = 1'b1;
    if ({araddr[7:2], 2'b00} == `OFF_CTRL) begin
      rd_word = ctrl_q;
    end else if ({araddr[7:2], 2'b00} == `OFF_TIME) begin
      rd_word = time_now;
    end else if ({araddr[7:2], 2'b00} == `OFF_DAY) begin
      rd_word = day_now;
    end else if ({araddr[7:2], 2'b00} == `OFF_AL1_TIME) begin
      rd_word = al1_q;
    end else if ({araddr[7:2], 2'b00} == `OFF_AL2_TIME) begin
      rd_word = al2_time_q;
    end else if ({araddr[7:2], 2'b00} == `OFF_AL2_DAY) begin
      rd_word = al2_day_q;
    end else if ({araddr[7:2], 2'b00} == `OFF_SW) begin
      rd_word = 32'(sw_q);
    end else if ({araddr[7:2], 2'b00} == `OFF_STAT) begin
      rd_word = {25'h0000000, stat_q};
    end else begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b0;
    end
  end

  assign arready = !rvalid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  prescale_wrap_a: assert property (one_hz_tick |=> presc_q == '0) // RULE1
    else $error("prescaler did not restart after the 1 Hz tick");
  time_range_a: assert property (sec < 6'd60 && min < 6'd60 && hour < 5'd24) // RULE2
    else $error("time field out of range");
  sec_carry_a: assert property (sec_wrap && !min_wrap && !(wr_fire && waddr_q == `OFF_TIME)
    |=> sec == 6'd0 && min == $past(min) + 6'd1) // RULE10
    else $error("seconds wrap did not carry into minutes");
  day_roll_a: assert property (hour_wrap && !(wr_fire && waddr_q == `OFF_DAY)
    |=> day == 15'($past(day) + 15'd1) && hour == 5'd0) // RULE10
    else $error("hour wrap did not advance the day");
  alarm_cause_a: assert property (alarm1_irq |-> $past(al1_match) && $past(ctrl_q[`CTRL_AL1])) // RULE3
    else $error("alarm one fired without a match");
  alarm_day_a: assert property (alarm2_irq |-> $past(day_now) == $past(al2_day_q)) // RULE4
    else $error("alarm two fired on the wrong day");
  sw_count_a: assert property ((sw_state_q == rtc_pkg::SW_RUN) && one_hz_tick && sw_q != '0
    && !(wr_fire && waddr_q == `OFF_SW) |=> sw_q == $past(sw_q) - 1'b1) // RULE5
    else $error("stopwatch did not decrement on the tick");
  sw_under_a: assert property (sw_under && ctrl_q[`CTRL_SW]
    |=> stopwatch_irq && sw_state_q == rtc_pkg::SW_IDLE) // RULE6
    else $error("stopwatch underflow not signalled");
  tick_sec_a: assert property (one_hz_tick && ctrl_q[`CTRL_TSEC] |=> tick_irq) // RULE7
    else $error("second tick event missing");
  cal_rise_a: assert property (one_hz_tick |=> ##1 one_hz_calibration_out) // RULE8
    else $error("calibration output not high after the 1 Hz tick");

  sec_carry_c: cover property (sec_wrap);
  alarm_two_c: cover property (alarm2_irq);
  sw_under_c: cover property (stopwatch_irq);
endmodule : rtc_calendar
`default_nettype wire

// [rtc_params.svh]
// Constants for the real-time clock: offsets, field positions, reset values and counts.
// Contract
// RULE1: Crystal 32.768 kHz prescaled down to 1 Hz.
// RULE2: Seconds, minutes, hours, 32768-day counters.
// RULE3: Enabled alarm interrupts when time equals alarm.
// RULE4: Alarm one time-of-day; alarm two day plus time.
// RULE5: Stopwatch loads count, decrements once per second.
// RULE6: Enabled stopwatch interrupts on counter underflow.
// RULE7: Selectable second, minute, hour, day tick interrupts.
// RULE8: Calibration output runs at 1 Hz.
// RULE9: Keeps counting from crystal while system sleeps. The crystal is sampled on core_clk, so counting stops when core_clk stops.
// RULE10: Counters carry upward; day counter rolls to zero.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define XTAL_HZ 32768
`define TIME_BASE_HZ 1
`define PRESCALE_DIV (`XTAL_HZ / `TIME_BASE_HZ)
`define SEC_MOD 60
`define MIN_MOD 60
`define HOUR_MOD 24
`define DAY_MOD 32768
`define SW_WIDTH 16
`define OFF_CTRL 8'h00
`define OFF_TIME 8'h04
`define OFF_DAY 8'h08
`define OFF_AL1_TIME 8'h0C
`define OFF_AL2_TIME 8'h10
`define OFF_AL2_DAY 8'h14
`define OFF_SW 8'h18
`define OFF_STAT 8'h1C
`define CTRL_RUN 0
`define CTRL_AL1 1
`define CTRL_AL2 2
`define CTRL_SW 3
`define CTRL_TSEC 4
`define CTRL_TMIN 5
`define CTRL_THOUR 6
`define CTRL_TDAY 7
`define CTRL_RST 32'h0000_0001
`define TIME_SEC_LSB 0
`define TIME_MIN_LSB 8
`define TIME_HOUR_LSB 16
`define TIME_MASK 32'h001F_3F3F
`define DAY_MASK 32'h0000_7FFF
`define ST_AL1 0
`define ST_AL2 1
`define ST_SW 2
`define ST_TSEC 3
`define ST_TMIN 4
`define ST_THOUR 5
`define ST_TDAY 6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtc_pkg.sv]
// Types shared by the real-time clock files.
`default_nettype none
package rtc_pkg;
  typedef enum logic {SW_IDLE, SW_RUN} sw_state_e;
  typedef logic [6:0] evt_t;
endpackage : rtc_pkg
`default_nettype wire

// [rtc_wrap_counter.sv]
// Loadable modulo counter with a carry pulse for the time-of-day cascade.
`timescale 1ns/1ps
`default_nettype none
module rtc_wrap_counter #(
  parameter int W = 6,
  parameter int MOD = 60
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] value,
  output logic wrap
);
  localparam logic [W-1:0] LAST = W'(MOD - 1);

  assign wrap = inc && !load && (value == LAST); // RULE10

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      value <= '0;
    end else if (load) begin
      // Out-of-range values would never reach the wrap point, so they load as zero.
      value <= (load_val > LAST) ? '0 : load_val;
    end else if (inc) begin
      value <= (value == LAST) ? '0 : value + 1'b1; // RULE2
    end
  end
endmodule : rtc_wrap_counter
`default_nettype wire

// [rtc_xtal_model.sv]
// Behavioural crystal that drives the reference input of the real-time clock.
`timescale 1ns/1ps
`default_nettype none
module rtc_xtal_model #(
  parameter realtime HALF_NS = 15258.789
) (
  output logic xtal_out
);
  // A crystal oscillates freely, so the reference never stands still.
  initial begin
    xtal_out = 1'b0;
    forever #(HALF_NS) xtal_out = ~xtal_out;
  end
endmodule : rtc_xtal_model
`default_nettype wire

// [rtc_calendar_alarm_stopwatch_tb_top.sv]
// Self-checking testbench for the real-time clock block.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module rtc_calendar_alarm_stopwatch_tb_top;
  localparam int PRE = 4;
  localparam int SEC_CYC = PRE * 30518 / 25;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic xtal_in;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic cal_out;
  logic al1_irq;
  logic al2_irq;
  logic sw_irq;
  logic tick_irq;
  int mismatches = 0;
  int num_checks = 0;
  int al1_n = 0;
  int al2_n = 0;
  int sw_n = 0;
  int tick_n = 0;

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  rtc_xtal_model xtal_u (.xtal_out(xtal_in));

  rtc_calendar #(.PRESCALE(PRE)) dut_u (.core_clk(core_clk), .rst(rst), .xtal_in(xtal_in),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .one_hz_calibration_out(cal_out),
    .alarm1_irq(al1_irq), .alarm2_irq(al2_irq), .stopwatch_irq(sw_irq), .tick_irq(tick_irq));

  // Pulses last one cycle, so they are counted at every edge.
  always @(posedge core_clk) begin
    if (al1_irq === 1'b1) al1_n <= al1_n + 1;
    if (al2_irq === 1'b1) al2_n <= al2_n + 1;
    if (sw_irq === 1'b1) sw_n <= sw_n + 1;
    if (tick_irq === 1'b1) tick_n <= tick_n + 1;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up(input string what);
    mismatches++;
    $display("unexpected timeout in %s: expected an answer seen none", what);
    final_report();
  endtask : give_up

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      n++;
      if (n > 200) give_up("write");
    end
    chk("write response", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input string what, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      n++;
      if (n > 200) give_up("read");
    end
    chk(what, ed, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_rd

  function automatic int evt_cnt(input int sel);
    case (sel)
      0: return al1_n;
      1: return al2_n;
      2: return sw_n;
      default: return tick_n;
    endcase
  endfunction : evt_cnt

  task automatic wait_evt(input int sel, input int lim, output int w);
    int base;
    base = evt_cnt(sel);
    w = 0;
    while (evt_cnt(sel) == base) begin
      @(posedge core_clk);
      w++;
      if (w > lim) give_up("event wait");
    end
  endtask : wait_evt

  task automatic level_len(input logic lv, output int n);
    n = 0;
    while (cal_out === lv) begin
      @(posedge core_clk);
      n++;
      if (n > 2 * SEC_CYC) give_up("calibration level");
    end
  endtask : level_len

  task automatic t_reset();
    axi_rd(`OFF_CTRL, "control reset", `CTRL_RST, `RESP_OKAY);
    axi_rd(`OFF_SW, "stopwatch reset", 32'h0, `RESP_OKAY);
    axi_rd(8'h20, "unmapped read", 32'h0, `RESP_SLVERR);
    axi_wr(8'h20, 32'hFFFF_FFFF, `RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rollover();
    int w;
    axi_wr(`OFF_CTRL, 32'h0000_00F1, `RESP_OKAY);
    wait_evt(3, 2 * SEC_CYC, w);
    axi_wr(`OFF_DAY, 32'h0000_7FFF, `RESP_OKAY);
    axi_wr(`OFF_TIME, 32'h0017_3B3B, `RESP_OKAY);
    wait_evt(3, 2 * SEC_CYC, w);
    chk("second length", 32'h1, {31'h0, w > SEC_CYC - 40 && w < SEC_CYC + 5});
    axi_rd(`OFF_TIME, "time after wrap", 32'h0, `RESP_OKAY);
    axi_rd(`OFF_DAY, "day after wrap", 32'h0, `RESP_OKAY);
    axi_rd(`OFF_STAT, "tick status", 32'h0000_0078, `RESP_OKAY);
    axi_wr(`OFF_STAT, 32'h0000_007F, `RESP_OKAY);
    axi_rd(`OFF_STAT, "status cleared", 32'h0000_0000, `RESP_OKAY);
    $display("test rollover done");
  endtask : t_rollover

  task automatic t_alarm();
    int w;
    int a2;
    axi_wr(`OFF_CTRL, 32'h0000_0017, `RESP_OKAY);
    wait_evt(3, 2 * SEC_CYC, w);
    axi_wr(`OFF_AL1_TIME, 32'h0001_0204, `RESP_OKAY);
    axi_wr(`OFF_AL2_TIME, 32'h0001_0205, `RESP_OKAY);
    axi_wr(`OFF_AL2_DAY, 32'h0000_0005, `RESP_OKAY);
    axi_wr(`OFF_DAY, 32'h0000_0005, `RESP_OKAY);
    axi_wr(`OFF_TIME, 32'h0001_0203, `RESP_OKAY);
    wait_evt(0, 2 * SEC_CYC, w);
    axi_rd(`OFF_TIME, "time at first alarm", 32'h0001_0204, `RESP_OKAY);
    wait_evt(1, 2 * SEC_CYC, w);
    axi_rd(`OFF_TIME, "time at second alarm", 32'h0001_0205, `RESP_OKAY);
    a2 = al2_n;
    axi_wr(`OFF_AL2_DAY, 32'h0000_0006, `RESP_OKAY);
    axi_wr(`OFF_TIME, 32'h0001_0204, `RESP_OKAY);
    wait_evt(3, 2 * SEC_CYC, w);
    wait_evt(3, 2 * SEC_CYC, w);
    chk("second alarm on wrong day", a2, al2_n);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_stopwatch();
    int w;
    axi_wr(`OFF_CTRL, 32'h0000_0019, `RESP_OKAY);
    wait_evt(3, 2 * SEC_CYC, w);
    axi_wr(`OFF_SW, 32'h0000_0002, `RESP_OKAY);
    axi_rd(`OFF_SW, "stopwatch load", 32'h0000_0002, `RESP_OKAY);
    wait_evt(2, 4 * SEC_CYC, w);
    chk("underflow delay", 32'h1, {31'h0, w > 3 * SEC_CYC - 60 && w < 3 * SEC_CYC + 10});
    axi_rd(`OFF_SW, "stopwatch after underflow", 32'h0, `RESP_OKAY);
    $display("test stopwatch done");
  endtask : t_stopwatch

  task automatic t_cal();
    int h;
    int l;
    level_len(1'b1, h);
    level_len(1'b0, l);
    level_len(1'b1, h);
    level_len(1'b0, l);
    chk("calibration high", 32'h1, {31'h0, h > SEC_CYC / 2 - 10 && h < SEC_CYC / 2 + 10});
    chk("calibration low", 32'h1, {31'h0, l > SEC_CYC / 2 - 10 && l < SEC_CYC / 2 + 10});
    $display("test calibration done");
  endtask : t_cal

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_rollover();
    t_alarm();
    t_stopwatch();
    t_cal();
    final_report();
  end
endmodule : rtc_calendar_alarm_stopwatch_tb_top
`default_nettype wire
